// ==== drm_pkg.sv ====
package drm_pkg;

	// Register byte offsets on the Wishbone slave
	localparam int        ADR_W      = 4;
	localparam logic [3:0] ADR_CTRL   = 4'h0;
	localparam logic [3:0] ADR_HOSTWR = 4'h4;
	localparam logic [3:0] ADR_MONSEL = 4'h8;
	localparam logic [3:0] ADR_STATUS = 4'hc;

	// Control register bit positions
	localparam int CR_REF_VALUE = 12;
	localparam int CR_MON_EN    = 11;
	localparam int CR_INT_REF   = 10;

	// Reset values
	localparam logic [13:0] CTRL_RESET    = 14'h0000;
	localparam logic [5:0]  MON_SEL_RESET = 6'h3f;

	// Host word decode
	localparam logic [1:0] DEST_SFR     = 2'h0;
	localparam logic [5:0] SFR_ADDR     = 6'h0c;
	localparam logic [5:0] MON_HIZ_ADDR = 6'h3f;
	localparam int         HOSTWORD_W   = 22;

	// Host write word as it sits in the low bits of the data bus
	typedef struct packed {
		logic [1:0]  dest;
		logic [5:0]  addr;
		logic [13:0] data;
	} drm_hostword_t;

	// Channel write handed to the channel data registers
	typedef struct packed {
		logic        valid;
		logic [1:0]  dest;
		logic [5:0]  addr;
		logic [13:0] data;
	} drm_chanwr_t;

	// Status word, bit 0 is outHold
	typedef struct packed {
		logic refValueHigh;
		logic intRefEn;
		logic monActive;
		logic monOe;
		logic outHold;
	} drm_status_t;

endpackage

// ==== drm_ctrl.sv ====
// Decided for this implementation: the Wishbone interface to the registers and the register offsets.
module drm_ctrl #(
	parameter int NUM_CH = 40
) (
	// Clock and resets
	input  wire logic                 core_clk,
	input  wire logic                 rst_n,
	input  wire logic                 hwReset_n,
	// Wishbone slave
	input  wire logic                 wbCyc,
	input  wire logic                 wbStb,
	input  wire logic                 wbWe,
	input  wire logic [3:0]           wbSel,
	input  wire logic [drm_pkg::ADR_W-1:0] wbAdr,
	input  wire logic [31:0]          wbWdata,
	output logic                      wbAck,
	output logic [31:0]               wbRdata,
	// Reference control
	output logic                      intRefEn,
	output logic                      refValueHigh,
	// Analog output clamp
	output logic                      outHold,
	// Channel monitor
	output logic                      monActive,
	output logic                      lastChannelOutputDacEn,
	output logic [5:0]                monSel,
	output logic                      monitorOutputPinOe,
	// Channel data writes
	output drm_pkg::drm_chanwr_t      chanWr
);

	localparam logic [5:0] NUM_CH6 = 6'(NUM_CH);

	logic                 ack_q;
	logic [31:0]          rdata_q;
	logic [13:0]          ctrl_q;
	logic [13:0]          ctrl_d;
	logic                 outHold_q;
	logic [5:0]           monSel_q;
	logic [5:0]           monSel_d;
	logic                 monOe_q;
	logic                 monOe_d;
	logic                 lastDac_q;
	logic                 monActive_q;
	drm_pkg::drm_chanwr_t chanWr_q;
	drm_pkg::drm_chanwr_t chanWr_d;
	drm_pkg::drm_status_t status;

	// Reset decode
	wire logic resetAll = ~rst_n | ~hwReset_n;

	// Bus decode
	wire logic reqNew  = wbCyc & wbStb & ~ack_q;
	wire logic wrTake  = wbCyc & wbStb & wbWe & ack_q;
	wire logic hitCtrl = wbAdr == drm_pkg::ADR_CTRL;
	wire logic hitHost = wbAdr == drm_pkg::ADR_HOSTWR;
	wire logic hitMon  = wbAdr == drm_pkg::ADR_MONSEL;
	wire logic hitStat = wbAdr == drm_pkg::ADR_STATUS;

	// Host word decode; a write missing any of byte lanes 0 to 2 carries no complete word and is ignored
	wire drm_pkg::drm_hostword_t hostWord =
		drm_pkg::drm_hostword_t'(wbWdata[drm_pkg::HOSTWORD_W-1:0]);
	wire logic hostWr    = wrTake & hitHost & (&wbSel[2:0]);
	wire logic sfrHit    = (hostWord.dest == drm_pkg::DEST_SFR) &
		(hostWord.addr == drm_pkg::SFR_ADDR);
	wire logic sfrWr     = hostWr & sfrHit;
	wire logic chanValid = hostWord.addr < NUM_CH6;
	wire logic chanHit   = hostWr & ~sfrHit & chanValid;

	// Selection writes before monitor enable are dropped so the pin never glitches
	wire logic monEn    = ctrl_q[drm_pkg::CR_MON_EN];
	wire logic monSelWr = wrTake & hitMon & wbSel[0] & monEn;

	// Next-state values
	assign ctrl_d   = sfrWr ? hostWord.data : ctrl_q;
	assign monSel_d = monSelWr ? wbWdata[5:0] : monSel_q;
	assign monOe_d  = ctrl_d[drm_pkg::CR_MON_EN] &
		(monSel_d != drm_pkg::MON_HIZ_ADDR) & (monSel_d < NUM_CH6);

	assign chanWr_d.valid = chanHit;
	assign chanWr_d.dest  = chanHit ? hostWord.dest : chanWr_q.dest;
	assign chanWr_d.addr  = chanHit ? hostWord.addr : chanWr_q.addr;
	assign chanWr_d.data  = chanHit ? hostWord.data : chanWr_q.data;

	// Read mux
	assign status.refValueHigh = ctrl_q[drm_pkg::CR_REF_VALUE];
	assign status.intRefEn     = ctrl_q[drm_pkg::CR_INT_REF];
	assign status.monActive    = monEn;
	assign status.monOe        = monOe_q;
	assign status.outHold      = outHold_q;

	wire logic [31:0] rdataSel =
		hitCtrl ? {18'h00000, ctrl_q} :
		hitMon  ? {26'h0000000, monSel_q} :
		hitStat ? {27'h0000000, status} : 32'h00000000;

	// Wishbone answer: ack one cycle after the request appears, then dropped
	always_ff @(posedge core_clk) begin
		if (resetAll) begin
			ack_q   <= 1'b0;
			rdata_q <= 32'h00000000;
		end else begin
			ack_q   <= reqNew;
			rdata_q <= reqNew ? rdataSel : rdata_q;
		end
	end

	// Control register: defaults select the external reference
	always_ff @(posedge core_clk) begin
		if (resetAll) begin
			ctrl_q <= drm_pkg::CTRL_RESET;
		end else begin
			ctrl_q <= ctrl_d;
		end
	end

	// Outputs stay clamped at zero until a channel actually receives data
	always_ff @(posedge core_clk) begin
		if (resetAll) begin
			outHold_q <= 1'b1;
		end else if (chanHit) begin
			outHold_q <= 1'b0;
		end
	end

	// Monitor multiplexer and last channel pin ownership
	always_ff @(posedge core_clk) begin
		if (resetAll) begin
			monSel_q  <= drm_pkg::MON_SEL_RESET;
			monOe_q   <= 1'b0;
			lastDac_q <= 1'b1;
			monActive_q <= 1'b0;
		end else begin
			monSel_q  <= monSel_d;
			monOe_q   <= monOe_d;
			lastDac_q <= ~ctrl_d[drm_pkg::CR_MON_EN];
			// Own flop so the pin owner output is not an inverter after a register
			monActive_q <= ctrl_d[drm_pkg::CR_MON_EN];
		end
	end

	// Channel write strobe for the data registers
	always_ff @(posedge core_clk) begin
		if (resetAll) begin
			chanWr_q <= '0;
		end else begin
			chanWr_q <= chanWr_d;
		end
	end

	assign wbAck                  = ack_q;
	assign wbRdata                = rdata_q;
	assign intRefEn               = ctrl_q[drm_pkg::CR_INT_REF];
	assign refValueHigh           = ctrl_q[drm_pkg::CR_REF_VALUE];
	assign outHold                = outHold_q;
	assign monActive              = monActive_q;
	assign lastChannelOutputDacEn = lastDac_q;
	assign monSel                 = monSel_q;
	assign monitorOutputPinOe     = monOe_q;
	assign chanWr                 = chanWr_q;

	// Checks
	default clocking cb @(posedge core_clk);
	endclocking
	default disable iff (resetAll);

	chk_reset_defaults: assert property (
		disable iff (1'b0) !rst_n |=> outHold && !intRefEn && !monitorOutputPinOe
			&& ctrl_q == drm_pkg::CTRL_RESET)
		else $error("power-on reset did not restore defaults");

	chk_hold_release: assert property (
		outHold && !chanHit |=> outHold)
		else $error("output clamp released without a channel write");

	chk_hold_clears: assert property (
		chanHit |=> !outHold ##1 !outHold)
		else $error("output clamp not released after channel write");

	chk_hwreset_reload: assert property (
		disable iff (1'b0) rst_n && !hwReset_n |=> outHold && lastChannelOutputDacEn
			&& monSel == drm_pkg::MON_SEL_RESET && !wbAck)
		else $error("hardware reset did not reload defaults");

	chk_extref_kept: assert property (
		$rose(intRefEn) |-> $past(sfrWr))
		else $error("internal reference enabled without a control write");

	chk_ref_value: assert property (
		sfrWr |=> refValueHigh == $past(hostWord.data[drm_pkg::CR_REF_VALUE]))
		else $error("reference value select not taken from control write");

	chk_int_ref: assert property (
		sfrWr |=> intRefEn == $past(hostWord.data[drm_pkg::CR_INT_REF]))
		else $error("internal reference select not taken from control write");

	chk_mon_route: assert property (
		monSelWr ##1 !monSelWr |-> monSel == $past(wbWdata[5:0], 2)
			&& monitorOutputPinOe == (monActive && monSel < NUM_CH6))
		else $error("monitor selection not routed");

	chk_last_chan: assert property (
		sfrWr |=> monActive == $past(hostWord.data[drm_pkg::CR_MON_EN])
			&& lastChannelOutputDacEn == !monActive)
		else $error("last channel pin ownership wrong");

	chk_mon_order: assert property (
		wrTake && hitMon && !monEn |=> $stable(monSel))
		else $error("monitor selection taken while monitor disabled");

	chk_mon_hiz: assert property (
		monSel == drm_pkg::MON_HIZ_ADDR |-> !monitorOutputPinOe)
		else $error("monitor pin driven with high impedance selection");

	chk_sfr_decode: assert property (
		sfrWr |=> !chanWr.valid && ctrl_q == $past(hostWord.data))
		else $error("control register write decoded as a channel write");

	chk_ack_pulse: assert property (
		reqNew |=> wbAck ##1 !wbAck)
		else $error("bus answer not a single cycle");

	chk_ack_idle: assert property (
		!wbCyc |=> !wbAck)
		else $error("bus answer without a cycle");

	chk_ctrl_ro: assert property (
		wrTake && hitCtrl |=> $stable(ctrl_q))
		else $error("control register changed by a read only offset");

	chk_partial_host: assert property (
		wrTake && hitHost && !(&wbSel[2:0]) |=> !chanWr.valid && $stable(ctrl_q))
		else $error("partial host word was not ignored");

	chk_chan_range: assert property (
		chanWr.valid |-> chanWr.addr < NUM_CH6)
		else $error("channel write beyond the last channel");

	chk_chan_fields: assert property (
		chanHit |=> chanWr.valid && chanWr.addr == $past(hostWord.addr)
			&& chanWr.data == $past(hostWord.data))
		else $error("channel write fields not passed on");

	chk_chan_pulse: assert property (
		chanWr.valid |=> !chanWr.valid)
		else $error("channel write strobe longer than one cycle");

	chk_oe_needs_mon: assert property (
		monitorOutputPinOe |-> monActive)
		else $error("monitor pin driven outside monitor mode");

	chk_last_pin_excl: assert property (
		lastChannelOutputDacEn != monActive)
		else $error("last channel pin has two owners or none");

	chk_oe_range: assert property (
		monitorOutputPinOe |-> monSel < NUM_CH6)
		else $error("monitor pin driven for a missing channel");

	chk_mon_taken: assert property (
		monSelWr |=> monSel == $past(wbWdata[5:0]))
		else $error("monitor selection not stored");

	chk_ctrl_hold: assert property (
		!sfrWr |=> $stable(ctrl_q))
		else $error("control register changed without a control write");

	chk_hold_stays: assert property (
		!outHold |=> !outHold)
		else $error("output clamp returned without a reset");

	chk_rdata_unmapped: assert property (
		reqNew && !hitCtrl && !hitMon && !hitStat |=> wbRdata == 32'h00000000)
		else $error("unmapped offset read back nonzero");

	chk_status_hold: assert property (
		reqNew && hitStat |=> wbRdata[0] == $past(outHold))
		else $error("status read shows wrong clamp state");

	chk_ack_reset: assert property (
		disable iff (1'b0) !hwReset_n |=> !wbAck && !chanWr.valid)
		else $error("hardware reset left bus or strobe active");

	chk_intref_off: assert property (
		$fell(intRefEn) |-> $past(sfrWr || resetAll))
		else $error("internal reference dropped without a control write");

	// Reset, reference, monitor and output clamp scenarios that the bench is expected to reach
	cov_hw_reset: cover property (disable iff (1'b0) !hwReset_n ##1 hwReset_n);
	cov_control_write: cover property (sfrWr ##1 intRefEn);
	cov_monitor_route: cover property (monSelWr ##1 monitorOutputPinOe);
	cov_monitor_hiz: cover property (monActive && monSel == drm_pkg::MON_HIZ_ADDR);
	cov_hold_release: cover property (outHold ##1 !outHold);

endmodule

// ==== drm_host.sv ====
module drm_host (
	// Clock
	input  wire logic        core_clk,
	// Wishbone master
	output logic             wbCyc,
	output logic             wbStb,
	output logic             wbWe,
	output logic [3:0]       wbSel,
	output logic [3:0]       wbAdr,
	output logic [31:0]      wbWdata,
	input  wire logic        wbAck,
	input  wire logic [31:0] wbRdata,
	// Reset pin
	output logic             hwReset_n
);
	timeunit 1ns;
	timeprecision 1ps;

	initial begin
		{wbCyc, wbStb, wbWe, wbSel, wbAdr, wbWdata} = '0;
		hwReset_n = 1'b1;
	end

	// Holds the whole request until ack is sampled, then idles one cycle
	task xfer(input logic we, input logic [3:0] adr, input logic [31:0] dat, input logic [3:0] sel);
		@(posedge core_clk);
		{wbCyc, wbStb, wbWe, wbAdr, wbWdata, wbSel} <= {2'b11, we, adr, dat, sel};
		do @(posedge core_clk); while (wbAck !== 1'b1);
		{wbCyc, wbStb, wbWe} <= 3'h0;
		@(posedge core_clk);
		#1;
	endtask

	task sfr(input logic [13:0] d);
		xfer(1'b1, drm_pkg::ADR_HOSTWR, {10'h0, drm_pkg::DEST_SFR, drm_pkg::SFR_ADDR, d}, 4'hf);
	endtask

	// Also used when supplies come up slowly, to force the defaults back in
	task pulseReset();
		@(posedge core_clk);
		hwReset_n <= 1'b0;
		repeat (2) @(posedge core_clk);
		hwReset_n <= 1'b1;
		@(posedge core_clk);
		#1;
	endtask
endmodule

// ==== drm_ctrl_tb.sv ====
module drm_ctrl_tb;
	timeunit 1ns;
	timeprecision 1ps;

	logic                 core_clk, rst_n, hwReset_n;
	logic                 wbCyc, wbStb, wbWe, wbAck;
	logic [3:0]           wbSel, wbAdr;
	logic [31:0]          wbWdata, wbRdata;
	logic                 intRefEn, refValueHigh, outHold, monActive;
	logic                 lastChannelOutputDacEn, monitorOutputPinOe;
	logic [5:0]           monSel;
	drm_pkg::drm_chanwr_t chanWr;
	logic [31:0]          expQ[$];
	logic [31:0]          seed = 32'hcd71;
	logic [5:0]           sels [6] = '{6'h00, 6'h27, 6'h28, 6'h3e, 6'h3f, 6'h11};
	int                   numErrors = 0;
	int                   checks = 0;

	initial begin
		core_clk = 1'b0;
		forever #4 core_clk = ~core_clk;
	end

	drm_ctrl #(.NUM_CH(40)) dut (.core_clk(core_clk), .rst_n(rst_n), .hwReset_n(hwReset_n),
		.wbCyc(wbCyc), .wbStb(wbStb), .wbWe(wbWe), .wbSel(wbSel), .wbAdr(wbAdr),
		.wbWdata(wbWdata), .wbAck(wbAck), .wbRdata(wbRdata), .intRefEn(intRefEn),
		.refValueHigh(refValueHigh), .outHold(outHold), .monActive(monActive),
		.lastChannelOutputDacEn(lastChannelOutputDacEn), .monSel(monSel),
		.monitorOutputPinOe(monitorOutputPinOe), .chanWr(chanWr));

	drm_host host (.core_clk(core_clk), .wbCyc(wbCyc), .wbStb(wbStb), .wbWe(wbWe),
		.wbSel(wbSel), .wbAdr(wbAdr), .wbWdata(wbWdata), .wbAck(wbAck),
		.wbRdata(wbRdata), .hwReset_n(hwReset_n));

	function logic [31:0] rnd();
		seed = seed ^ (seed << 13);
		seed = seed ^ (seed >> 17);
		seed = seed ^ (seed << 5);
		return seed;
	endfunction

	task chk(input logic [31:0] got, input logic [31:0] exp);
		checks++;
		if (got !== exp) begin
			numErrors++;
			$display("[ERR] %0t got %h exp %h", $time, got, exp);
		end
	endtask

	// Order: intRefEn, refValueHigh, outHold, monActive, last channel DAC, monitor drive
	task outs(input logic [5:0] exp);
		chk({26'h0, intRefEn, refValueHigh, outHold, monActive, lastChannelOutputDacEn,
			monitorOutputPinOe}, {26'h0, exp});
	endtask

	task rd(input logic [3:0] a, input logic [31:0] e);
		expQ.push_back(e);
		host.xfer(1'b0, a, 32'h0, 4'hf);
	endtask

	task chan(input logic [1:0] dst, input logic [5:0] a, input logic [13:0] d);
		expQ.push_back({9'h0, 1'b1, dst, a, d});
		host.xfer(1'b1, drm_pkg::ADR_HOSTWR, {10'h0, dst, a, d}, 4'hf);
	endtask

	task monWr(input logic [5:0] s);
		host.xfer(1'b1, drm_pkg::ADR_MONSEL, {26'h0, s}, 4'hf);
	endtask

	// Results are settled by the falling edge; queue order follows the driver
	always @(negedge core_clk) begin
		if (wbAck === 1'b1 && wbWe === 1'b0)
			chk(wbRdata, expQ.pop_front());
		if (chanWr.valid === 1'b1)
			chk({9'h0, chanWr}, expQ.pop_front());
	end

	task complete_run();
		$display("checks %0d errors %0d", checks, numErrors);
		if (numErrors == 0 && checks > 0)
			$display("ALL CHECKS OK");
		else
			$display("CHECKS NOT OK");
		$finish;
	endtask

	initial begin
		#20000;
		numErrors++;
		complete_run();
	end

	initial begin
		logic [5:0]  s;
		logic [1:0]  dst;
		rst_n = 1'b0;
		repeat (2) @(posedge core_clk);
		rst_n <= 1'b1;
		@(posedge core_clk);
		#1;
		outs(6'b001010);
		chk({26'h0, monSel}, 32'h3f);
		rd(drm_pkg::ADR_STATUS, 32'h1);
		monWr(6'h05);
		chk({26'h0, monSel}, 32'h3f);
		host.sfr(14'h0400);
		outs(6'b101010);
		host.sfr(14'h1000);
		outs(6'b011010);
		host.sfr(14'h1c00);
		outs(6'b111100);
		host.xfer(1'b1, drm_pkg::ADR_CTRL, 32'h0, 4'hf);
		rd(drm_pkg::ADR_CTRL, 32'h1c00);
		rd(4'h2, 32'h0);
		host.xfer(1'b1, drm_pkg::ADR_HOSTWR, {10'h0, drm_pkg::DEST_SFR, drm_pkg::SFR_ADDR, 14'h0}, 4'h3);
		rd(drm_pkg::ADR_CTRL, 32'h1c00);
		host.xfer(1'b1, drm_pkg::ADR_HOSTWR, {10'h0, 2'h1, 6'h30, 14'h1}, 4'hf);
		outs(6'b111100);
		for (int i = 0; i < 6; i++) begin
			s = (i == 5) ? 6'(rnd() % 40) : sels[i];
			monWr(s);
			chk({25'h0, monSel, monitorOutputPinOe}, {25'h0, s, s < 6'd40});
		end
		for (int i = 0; i < 8; i++) begin
			dst = 2'(rnd());
			s = 6'(rnd() % 40);
			if (dst == 2'h0 && s == 6'h0c)
				s = 6'h0d;
			chan(dst, s, 14'(rnd()));
		end
		outs(6'b110101);
		host.pulseReset();
		outs(6'b001010);
		chk({26'h0, monSel}, 32'h3f);
		rd(drm_pkg::ADR_CTRL, 32'h0);
		complete_run();
	end
endmodule
